// ===== shared/doimg_defs.svh
`ifndef DOIMG_DEFS_SVH
`define DOIMG_DEFS_SVH
// register byte offsets
`define DOIMG_REG_OUT      4'h0
`define DOIMG_REG_IN       4'h4
`define DOIMG_REG_CFG      4'h8
`define DOIMG_REG_ANLEN    4'hc
// variant codes (cfg bits 2:0)
`define DOIMG_V_DO2        3'h0
`define DOIMG_V_DO2_DIAG   3'h1
`define DOIMG_V_DO2_CODE   3'h2
`define DOIMG_V_DO4        3'h3
`define DOIMG_V_DO4_DIAG   3'h4
`define DOIMG_V_DO8        3'h5
`define DOIMG_V_DO8_DIAG   3'h6
// 2-bit fault codes
`define DOIMG_CODE_NONE    2'h0
`define DOIMG_CODE_OVL     2'h1
`define DOIMG_CODE_SHORT   2'h2
`define DOIMG_CODE_OPEN    2'h3
// reset values
`define DOIMG_RST_OUT      8'h00
`define DOIMG_RST_CFG      3'h6
`define DOIMG_RST_ANLEN    8'h00
`endif

// ===== shared/doimg_pkg.sv
package doimg_pkg;
   typedef struct packed {
      logic [2:0] ovl;
      logic [2:0] shrt;
      logic [2:0] open;
   } doimg_sync_t;
   typedef struct packed {
      logic [7:0]  out_img;
      logic [2:0]  variant;
      logic [7:0]  an_len;
      logic [7:0]  in_img;
      logic [31:0] rdata;
      logic        ack;
      logic [7:0]  dout;
      doimg_sync_t s0;
      doimg_sync_t s1;
      doimg_sync_t s2;
      logic [7:0]  f_ovl;
      logic [7:0]  f_shrt;
      logic [7:0]  f_open;
   } doimg_state_t;
endpackage

// ===== src/doimg_top.sv
// Purpose: digital output process-image mapper with per-channel fault diagnostics
// Assumes: 200 MHz mclk, fault sensor pins asynchronous to mclk
// Notes:   Avalon-MM slave with waitrequest; variant chosen by software
//
// Function
// - set a channel fault flag on overload, short circuit or open wire
// - faults go to the input image; controls come only from output image
// - two-channel flag variant: in bits 0,1 = ch1,ch2 faults; out bits 0,1
// - richer two-channel variant gives a two-bit code per channel
// - code variant: in bits 0-1 ch1, 2-3 ch2; out bits 2,3 unused
// - four-channel: out bits 0-3 drive channels 1-4; bits 4-7 unused
// - four-channel diagnostic: in bits 0-3 carry channel 1-4 faults
// - fault flag zero means no error
// - fault flag one means overload, short circuit or open wire
// - eight-channel: out bits 0-7 drive channels 1-8
// - each output channel is driven by exactly one output-image bit
// - digital output bytes placed after analog data in output image
`include "doimg_defs.svh"
module doimg_top
   import doimg_pkg::*;
(
   input  wire logic        mclk,
   input  wire logic        nrst,
   input  wire logic [3:0]  avs_address,
   input  wire logic        avs_read,
   input  wire logic        avs_write,
   input  wire logic [31:0] avs_writedata,
   input  wire logic [3:0]  avs_byteenable,
   output logic [31:0]      avs_readdata,
   output logic             avs_waitrequest,
   input  wire logic [7:0]  flt_ovl,
   input  wire logic [7:0]  flt_short,
   input  wire logic [7:0]  flt_open,
   output logic [7:0]       dout,
   output logic [7:0]       dout_byte_offset
);

   ////////////////////////////////////////////////////////////////////////
   // channel count and usable output mask per variant
   function automatic logic [7:0] out_mask(input logic [2:0] v);
      unique case (v)
         `DOIMG_V_DO2, `DOIMG_V_DO2_DIAG, `DOIMG_V_DO2_CODE: out_mask = 8'h03;
         `DOIMG_V_DO4, `DOIMG_V_DO4_DIAG: out_mask = 8'h0f;
         `DOIMG_V_DO8, `DOIMG_V_DO8_DIAG: out_mask = 8'hff;
         default: out_mask = 8'h00;
      endcase
   endfunction

   // two-bit code, short wins over overload over open wire
   function automatic logic [1:0] code_of(input logic o, input logic s, input logic w);
      if (s)
         code_of = `DOIMG_CODE_SHORT;
      else if (o)
         code_of = `DOIMG_CODE_OVL;
      else if (w)
         code_of = `DOIMG_CODE_OPEN;
      else
         code_of = `DOIMG_CODE_NONE;
   endfunction

   ////////////////////////////////////////////////////////////////////////
   doimg_state_t st_ff;
   doimg_state_t nxt_st;
   logic [7:0]   flag;
   logic         hit;

   always_comb begin
      nxt_st = st_ff;
      nxt_st.s0 = '{ovl: {flt_ovl[2:0]}, shrt: {flt_short[2:0]}, open: {flt_open[2:0]}};
      nxt_st.s1 = st_ff.s0;
      nxt_st.s2 = st_ff.s1;
      // the struct-based sync only covers 3 ch; full width handled below
      nxt_st.f_ovl  = st_ff.f_ovl;
      nxt_st.f_shrt = st_ff.f_shrt;
      nxt_st.f_open = st_ff.f_open;
      nxt_st.ack    = 1'b0;
      hit = (avs_read | avs_write) & ~st_ff.ack;
      // faults map to input image only
      flag = st_ff.f_ovl | st_ff.f_shrt | st_ff.f_open;
      nxt_st.in_img = 8'h00; // unused bits zero
      unique case (st_ff.variant)
         `DOIMG_V_DO2_DIAG: nxt_st.in_img = {6'h00, flag[1:0]};
         `DOIMG_V_DO2_CODE: nxt_st.in_img = {4'h0,
               code_of(st_ff.f_ovl[1], st_ff.f_shrt[1], st_ff.f_open[1]),
               code_of(st_ff.f_ovl[0], st_ff.f_shrt[0], st_ff.f_open[0])};
         `DOIMG_V_DO4_DIAG: nxt_st.in_img = {4'h0, flag[3:0]};
         `DOIMG_V_DO8_DIAG: nxt_st.in_img = flag;
         default: nxt_st.in_img = 8'h00;
      endcase
      // one image bit per channel, masked by variant
      nxt_st.dout = st_ff.out_img & out_mask(st_ff.variant);
      // write lands at the edge where the master sees waitrequest low
      if (st_ff.ack && avs_write && avs_byteenable[0]) begin
         unique case (avs_address)
            `DOIMG_REG_OUT: nxt_st.out_img = avs_writedata[7:0] & out_mask(st_ff.variant);
            `DOIMG_REG_CFG: nxt_st.variant = avs_writedata[2:0];
            `DOIMG_REG_ANLEN: nxt_st.an_len = avs_writedata[7:0];
            default: ;
         endcase
      end
      if (hit) begin
         nxt_st.ack = 1'b1;
         unique case (avs_address)
            `DOIMG_REG_OUT: nxt_st.rdata = {24'h0, st_ff.out_img};
            `DOIMG_REG_IN: nxt_st.rdata = {24'h0, st_ff.in_img};
            `DOIMG_REG_CFG: nxt_st.rdata = {29'h0, st_ff.variant};
            `DOIMG_REG_ANLEN: nxt_st.rdata = {24'h0, st_ff.an_len};
            default: nxt_st.rdata = 32'h0;
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // full-width fault synchronisers, level-following flags
   logic [7:0] o0_ff, o1_ff, o2_ff, s0_ff, s1_ff, s2_ff, w0_ff, w1_ff, w2_ff;
   logic [7:0] fo_ff, fs_ff, fw_ff;
   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         o0_ff <= 8'h00; o1_ff <= 8'h00; o2_ff <= 8'h00;
         s0_ff <= 8'h00; s1_ff <= 8'h00; s2_ff <= 8'h00;
         w0_ff <= 8'h00; w1_ff <= 8'h00; w2_ff <= 8'h00;
         fo_ff <= 8'h00; fs_ff <= 8'h00; fw_ff <= 8'h00;
      end else begin
         o0_ff <= flt_ovl;   o1_ff <= o0_ff; o2_ff <= o1_ff;
         s0_ff <= flt_short; s1_ff <= s0_ff; s2_ff <= s1_ff;
         w0_ff <= flt_open;  w1_ff <= w0_ff; w2_ff <= w1_ff;
         // flag changes only when stages agree, filtering one-cycle glitches
         fo_ff <= (o1_ff & o2_ff) | (fo_ff & (o1_ff | o2_ff));
         fs_ff <= (s1_ff & s2_ff) | (fs_ff & (s1_ff | s2_ff));
         fw_ff <= (w1_ff & w2_ff) | (fw_ff & (w1_ff | w2_ff));
      end
   end

   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         st_ff         <= '0;
         st_ff.variant <= `DOIMG_RST_CFG;
      end else begin
         st_ff        <= nxt_st;
         st_ff.f_ovl  <= fo_ff;
         st_ff.f_shrt <= fs_ff;
         st_ff.f_open <= fw_ff;
      end
   end

   assign avs_waitrequest  = (avs_read | avs_write) & ~st_ff.ack;
   assign avs_readdata     = st_ff.rdata;
   assign dout             = st_ff.dout;
   assign dout_byte_offset = st_ff.an_len; // digital bytes start after analog bytes

   ////////////////////////////////////////////////////////////////////////
   unused_out_a: assert property (@(posedge mclk) disable iff (!nrst)
      (st_ff.variant inside {`DOIMG_V_DO2, `DOIMG_V_DO2_DIAG, `DOIMG_V_DO2_CODE} && $stable(st_ff.variant))
      |=> dout[7:2] == 6'h00)
      else $error("unused output bit driven");
   four_ch_a: assert property (@(posedge mclk) disable iff (!nrst)
      (st_ff.variant == `DOIMG_V_DO4 && $stable(st_ff.variant)) |=> dout[7:4] == 4'h0)
      else $error("four channel high bits driven");
   out_follow_a: assert property (@(posedge mclk) disable iff (!nrst)
      (st_ff.variant == `DOIMG_V_DO8 && $stable(st_ff.variant)) |=> dout == $past(st_ff.out_img))
      else $error("output does not follow image");
   fault_set_a: assert property (@(posedge mclk) disable iff (!nrst)
      (flt_short[0] [*6]) |-> st_ff.f_shrt[0])
      else $error("short not flagged");
   fault_clr_a: assert property (@(posedge mclk) disable iff (!nrst)
      (!flt_ovl[0] && !flt_short[0] && !flt_open[0]) [*7] |-> !(st_ff.f_ovl[0] | st_ff.f_shrt[0] | st_ff.f_open[0]))
      else $error("flag stuck after fault gone");
   diag8_a: assert property (@(posedge mclk) disable iff (!nrst)
      (st_ff.variant == `DOIMG_V_DO8_DIAG && $stable(st_ff.variant)) |=> st_ff.in_img == $past(flag))
      else $error("diag image mismatch");
   in_unused_a: assert property (@(posedge mclk) disable iff (!nrst)
      st_ff.variant == `DOIMG_V_DO4_DIAG |=> st_ff.in_img[7:4] == 4'h0)
      else $error("unused input bits set");
   code_ok_a: assert property (@(posedge mclk) disable iff (!nrst)
      (st_ff.variant == `DOIMG_V_DO2_CODE && !(|flag[1:0]) && $stable(flag)) |=> st_ff.in_img == 8'h00)
      else $error("code nonzero without fault");
   no_fault_a: assert property (@(posedge mclk) disable iff (!nrst)
      (st_ff.variant == `DOIMG_V_DO2_DIAG && !flag[0]) |=> !st_ff.in_img[0])
      else $error("flag without fault");
endmodule

// ===== verification/doimg_coupler.sv
// Purpose: coupler model, Avalon-MM master reaching the process images
// Assumes: one request in flight at a time
// Notes:   request held until waitrequest is sampled low
module doimg_coupler
   import doimg_pkg::*;
(
   input  wire logic        mclk,
   input  wire logic        avs_waitrequest,
   input  wire logic [31:0] avs_readdata,
   output logic [3:0]       avs_address,
   output logic             avs_read,
   output logic             avs_write,
   output logic [31:0]      avs_writedata
);
   timeunit 1ns;
   timeprecision 1ps;
   initial begin
      avs_address = 4'h0;
      avs_read = 1'b0;
      avs_write = 1'b0;
      avs_writedata = 32'h0;
   end
   ////////////////////////////////////////////////////////////////////////
   // iff sees waitrequest as it was before this edge's updates
   task automatic xfer(input logic w, input logic [3:0] a, input logic [31:0] d, output logic [31:0] q);
      @(posedge mclk);
      avs_address   <= a;
      avs_read      <= ~w;
      avs_write     <= w;
      avs_writedata <= d;
      @(posedge mclk iff avs_waitrequest === 1'b0);
      q = avs_readdata;
      avs_read  <= 1'b0;
      avs_write <= 1'b0;
   endtask
   // both code bits taken together, never one alone
   function automatic logic [1:0] fault_kind(input logic [31:0] img, input int ch);
      return img[2*ch +: 2];
   endfunction
endmodule

// ===== verification/doimg_top_bench.sv
// Purpose: self-checking bench for the output image mapper
// Assumes: fault pins settle into the input image within 12 cycles
// Notes:   byte enables tied on, only lane 0 matters
`include "doimg_defs.svh"
`define CHK(g, e) begin tests_run++; if ((g) !== (e)) begin n_mismatch++; $display("unexpected at %0t: got %h expected %h", $time, (g), (e)); end end
module doimg_top_bench
   import doimg_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   logic        mclk, nrst, rd_s, wr_s, wait_s;
   logic [3:0]  addr;
   logic [31:0] wdata, rdata, q;
   logic [7:0]  f_ovl, f_short, f_open, dout, offs;
   int          n_mismatch = 0;
   int          tests_run = 0;
   doimg_top doimg_top_i(.mclk(mclk), .nrst(nrst), .avs_address(addr), .avs_read(rd_s), .avs_write(wr_s),
      .avs_writedata(wdata), .avs_byteenable(4'hf), .avs_readdata(rdata), .avs_waitrequest(wait_s),
      .flt_ovl(f_ovl), .flt_short(f_short), .flt_open(f_open), .dout(dout), .dout_byte_offset(offs));
   doimg_coupler doimg_coupler_i(.mclk(mclk), .avs_waitrequest(wait_s), .avs_readdata(rdata),
      .avs_address(addr), .avs_read(rd_s), .avs_write(wr_s), .avs_writedata(wdata));
   initial begin
      mclk = 1'b0;
      forever #2.5 mclk = ~mclk;
   end
   ////////////////////////////////////////////////////////////////////////
   task automatic wr(input logic [3:0] a, input logic [7:0] d);
      doimg_coupler_i.xfer(1'b1, a, {24'h0, d}, q);
   endtask
   task automatic rd(input logic [3:0] a);
      doimg_coupler_i.xfer(1'b0, a, 32'h0, q);
   endtask
   task automatic fault(input logic [7:0] o, input logic [7:0] s, input logic [7:0] p);
      @(posedge mclk);
      f_ovl   <= o;
      f_short <= s;
      f_open  <= p;
      repeat (12) @(posedge mclk);
   endtask
   task automatic out_chk(input logic [7:0] d, input logic [7:0] e);
      wr(`DOIMG_REG_OUT, d);
      repeat (3) @(posedge mclk);
      `CHK(dout, e)
   endtask
   ////////////////////////////////////////////////////////////////////////
   task automatic t_reset;
      `CHK(dout, 8'h00)
      rd(`DOIMG_REG_CFG);
      `CHK(q[2:0], `DOIMG_RST_CFG)
      rd(4'h2);
      `CHK(q, 32'h0)
   endtask
   task automatic t_widths;
      wr(`DOIMG_REG_CFG, {5'h0, `DOIMG_V_DO8});
      out_chk(8'ha5, 8'ha5);
      wr(`DOIMG_REG_CFG, {5'h0, `DOIMG_V_DO4});
      out_chk(8'hff, 8'h0f);
      wr(`DOIMG_REG_CFG, {5'h0, `DOIMG_V_DO2_CODE});
      out_chk(8'hff, 8'h03);
   endtask
   task automatic t_flag2;
      wr(`DOIMG_REG_CFG, {5'h0, `DOIMG_V_DO2_DIAG});
      out_chk(8'h5a, 8'h02);
      fault(8'h05, 8'h00, 8'h02);
      rd(`DOIMG_REG_IN);
      `CHK(q, 32'h3)
      fault(8'h00, 8'h00, 8'h00);
      rd(`DOIMG_REG_IN);
      `CHK(q, 32'h0)
   endtask
   task automatic t_code2;
      wr(`DOIMG_REG_CFG, {5'h0, `DOIMG_V_DO2_CODE});
      fault(8'h00, 8'h01, 8'h02);
      rd(`DOIMG_REG_IN);
      `CHK(q, 32'he)
      `CHK(doimg_coupler_i.fault_kind(q, 1), `DOIMG_CODE_OPEN)
      fault(8'h03, 8'h01, 8'h01);
      rd(`DOIMG_REG_IN);
      `CHK(doimg_coupler_i.fault_kind(q, 0), `DOIMG_CODE_SHORT)
      `CHK(doimg_coupler_i.fault_kind(q, 1), `DOIMG_CODE_OVL)
   endtask
   task automatic t_diag;
      wr(`DOIMG_REG_CFG, {5'h0, `DOIMG_V_DO4_DIAG});
      fault(8'h80, 8'h08, 8'h00);
      rd(`DOIMG_REG_IN);
      `CHK(q, 32'h8)
      wr(`DOIMG_REG_CFG, {5'h0, `DOIMG_V_DO8_DIAG});
      fault(8'h01, 8'h00, 8'h80);
      rd(`DOIMG_REG_IN);
      `CHK(q, 32'h81)
      wr(`DOIMG_REG_ANLEN, 8'h10);
      repeat (3) @(posedge mclk);
      `CHK(offs, 8'h10)
   endtask
   ////////////////////////////////////////////////////////////////////////
   task automatic print_verdict;
      $display("comparisons %0d mismatches %0d", tests_run, n_mismatch);
      if (n_mismatch == 0 && tests_run > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask
   initial begin
      #50us;
      n_mismatch++;
      print_verdict();
   end
   initial begin
      nrst = 1'b0;
      f_ovl = 8'h00;
      f_short = 8'h00;
      f_open = 8'h00;
      repeat (3) @(posedge mclk);
      nrst <= 1'b1;
      t_reset();
      t_widths();
      t_flag2();
      t_code2();
      t_diag();
      print_verdict();
   end
endmodule
